// [rtl/error_counter_preload.sv]
// What this block does
// - CRC-4 trigger rise loads CRC-4 counter
// - E-bit trigger rise loads E-bit counter
// - Bipolar trigger rise loads bipolar counter
// - Bipolar preset is high and low byte
// - Frame trigger rise loads frame counter
// - Alarm trigger rise loads alarm counter
// - BER trigger rise loads BER counter
// - BER preset transferred whole, eight bits
// - Preload acts only in serial backplane mode
`timescale 1ns/100ps
`include "preload_consts.svh"

module error_counter_preload
  import preload_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic [5:0] count_inc,
  output logic      [7:0] rd_data,
  output logic      [7:0] ber_count,
  output logic      [7:0] alarm_crc_count,
  output logic      [7:0] frame_align_count,
  output logic     [15:0] bipolar_count,
  output logic      [7:0] ebit_count,
  output logic      [7:0] crc4_count,
  output logic      [5:0] load_pulse
);

  byte_t            counter_load_control;
  logic             serial_mode;
  logic [5:0]       trigger_rise;
  logic [5:0]       next_load;
  logic [5:0]       inc_meta;
  logic [5:0]       inc_sync;
  logic [5:0]       inc_sync_d;
  logic [5:0]       inc_rise;
  logic             store_wr;
  logic [2:0]       store_wr_addr;
  byte_t            next_rd_data;
  byte_t            presets [8];
  byte_t            ber_preset_bits;
  byte_t            alarm_crc_preset_bits;
  byte_t            frame_align_preset_bits;
  logic [15:0]      bipolar_preset_bits;
  byte_t            ebit_preset_bits;
  byte_t            crc4_preset_bits;

  // Preset offsets 18h..1fh, except 1bh, map to store slots 0..7 (slot 3 unused)
  function automatic logic is_preset(input logic [4:0] a);
    return (a[4:3] == 2'b11) && (a != 5'h1b);
  endfunction : is_preset

  // Unused counter bits read as zero, saturating increment
  function automatic byte_t bump8(input byte_t v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction : bump8

  assign store_wr      = wr_stb && is_preset(addr);
  assign store_wr_addr = addr[2:0];

  preset_store #(
    .DEPTH (8)
  ) u_store (
    .clk       (clk),
    .rst_b     (rst_b),
    .wr_en     (store_wr),
    .wr_addr   (store_wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (addr[2:0]),
    .rd_data   (),
    .all_words (presets)
  );

  assign ber_preset_bits         = presets[3'(`OFF_BER_PRESET)];
  assign alarm_crc_preset_bits   = presets[3'(`OFF_ALARM_PRESET)];
  assign frame_align_preset_bits = presets[3'(`OFF_FRAME_PRESET)];
  assign bipolar_preset_bits     = {presets[3'(`OFF_BPV_PRESET_HI)],
                                    presets[3'(`OFF_BPV_PRESET_LO)]};
  assign ebit_preset_bits        = presets[3'(`OFF_EBIT_PRESET)];
  assign crc4_preset_bits        = presets[3'(`OFF_CRC4_PRESET)];

  // Load control word, only the six trigger bits are held
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      counter_load_control <= `RST_LOAD_CONTROL;
    end else if (wr_stb && addr == `OFF_LOAD_CONTROL) begin
      counter_load_control <= wr_data & `TRIGGER_MASK;
    end
  end

  // Mode control, bit 0 selects serial backplane mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      serial_mode <= 1'(`RST_MODE_CONTROL);
    end else if (wr_stb && addr == `OFF_MODE_CONTROL) begin
      serial_mode <= wr_data[0];
    end
  end

  rise_detect #(
    .WIDTH (6)
  ) u_rise (
    .clk   (clk),
    .rst_b (rst_b),
    .level (counter_load_control[5:0]),
    .rise  (trigger_rise)
  );

  // Rising edges only, gated by mode
  assign next_load = serial_mode ? trigger_rise : 6'h00;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      load_pulse <= 6'h00;
    end else begin
      load_pulse <= next_load;
    end
  end

  // Increment inputs come from another domain: two stages, then edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      inc_meta   <= 6'h00;
      inc_sync   <= 6'h00;
      inc_sync_d <= 6'h00;
    end else begin
      inc_meta   <= count_inc;
      inc_sync   <= inc_meta;
      inc_sync_d <= inc_sync;
    end
  end

  assign inc_rise = inc_sync & ~inc_sync_d;

  // BER counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ber_count <= `RST_COUNT;
    end else if (next_load[`BIT_BER_LOAD]) begin
      ber_count <= ber_preset_bits;
    end else if (inc_rise[CNT_BER]) begin
      ber_count <= bump8(ber_count);
    end
  end

  // Remote alarm and continuous CRC counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alarm_crc_count <= `RST_COUNT;
    end else if (next_load[`BIT_ALARM_LOAD]) begin
      alarm_crc_count <= alarm_crc_preset_bits;
    end else if (inc_rise[CNT_ALARM]) begin
      alarm_crc_count <= bump8(alarm_crc_count);
    end
  end

  // Errored frame alignment counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      frame_align_count <= `RST_COUNT;
    end else if (next_load[`BIT_FRAME_LOAD]) begin
      frame_align_count <= frame_align_preset_bits;
    end else if (inc_rise[CNT_FRAME]) begin
      frame_align_count <= bump8(frame_align_count);
    end
  end

  // Bipolar violation counter, both bytes on one trigger
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bipolar_count <= 16'h0000;
    end else if (next_load[`BIT_BPV_LOAD]) begin
      bipolar_count <= bipolar_preset_bits;
    end else if (inc_rise[CNT_BPV] && bipolar_count != 16'hffff) begin
      bipolar_count <= bipolar_count + 16'h0001;
    end
  end

  // E-bit error counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ebit_count <= `RST_COUNT;
    end else if (next_load[`BIT_EBIT_LOAD]) begin
      ebit_count <= ebit_preset_bits;
    end else if (inc_rise[CNT_EBIT]) begin
      ebit_count <= bump8(ebit_count);
    end
  end

  // CRC-4 error counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crc4_count <= `RST_COUNT;
    end else if (next_load[`BIT_CRC4_LOAD]) begin
      crc4_count <= crc4_preset_bits;
    end else if (inc_rise[CNT_CRC4]) begin
      crc4_count <= bump8(crc4_count);
    end
  end

  // Read word chosen while the strobe is high, zero otherwise
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_stb) begin
      case (addr)
        `OFF_LOAD_CONTROL:  next_rd_data = counter_load_control;
        `OFF_MODE_CONTROL:  next_rd_data = {7'h00, serial_mode};
        `OFF_BER_COUNT:     next_rd_data = ber_count;
        `OFF_ALARM_COUNT:   next_rd_data = alarm_crc_count;
        `OFF_FRAME_COUNT:   next_rd_data = frame_align_count;
        `OFF_BPV_COUNT_HI:  next_rd_data = bipolar_count[15:8];
        `OFF_BPV_COUNT_LO:  next_rd_data = bipolar_count[7:0];
        `OFF_EBIT_COUNT:    next_rd_data = ebit_count;
        `OFF_CRC4_COUNT:    next_rd_data = crc4_count;
        default: begin
          if (is_preset(addr)) begin
            next_rd_data = presets[addr[2:0]];
          end
        end
      endcase
    end
  end

  // Registered read data, stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule : error_counter_preload

// [rtl/preload_consts.svh]
`ifndef PRELOAD_CONSTS_SVH
`define PRELOAD_CONSTS_SVH

// Register offsets
`define OFF_LOAD_CONTROL   5'h15
`define OFF_BER_PRESET     5'h18
`define OFF_ALARM_PRESET   5'h19
`define OFF_FRAME_PRESET   5'h1a
`define OFF_BPV_PRESET_HI  5'h1c
`define OFF_BPV_PRESET_LO  5'h1d
`define OFF_EBIT_PRESET    5'h1e
`define OFF_CRC4_PRESET    5'h1f
`define OFF_MODE_CONTROL   5'h14
`define OFF_BER_COUNT      5'h08
`define OFF_ALARM_COUNT    5'h09
`define OFF_FRAME_COUNT    5'h0a
`define OFF_BPV_COUNT_HI   5'h0c
`define OFF_BPV_COUNT_LO   5'h0d
`define OFF_EBIT_COUNT     5'h0e
`define OFF_CRC4_COUNT     5'h0f

// Trigger bit positions in the load control word
`define BIT_CRC4_LOAD      5
`define BIT_EBIT_LOAD      4
`define BIT_BPV_LOAD       3
`define BIT_FRAME_LOAD     2
`define BIT_ALARM_LOAD     1
`define BIT_BER_LOAD       0
`define TRIGGER_MASK       8'h3f

// Reset values
`define RST_LOAD_CONTROL   8'h00
`define RST_PRESET         8'h00
`define RST_MODE_CONTROL   8'h01
`define RST_COUNT          8'h00

`endif

// [rtl/preload_pkg.sv]
package preload_pkg;

  // Counters served by the preload logic
  typedef enum {
    CNT_BER,
    CNT_ALARM,
    CNT_FRAME,
    CNT_BPV,
    CNT_EBIT,
    CNT_CRC4
  } counter_id_t;

  typedef logic [7:0] byte_t;

endpackage : preload_pkg

// [rtl/preset_store.sv]
`timescale 1ns/100ps
`include "preload_consts.svh"

// Small store of preset words, registered read port
module preset_store
  import preload_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire byte_t                    wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output byte_t                         rd_data,
  output byte_t                         all_words [DEPTH]
);

  byte_t mem [DEPTH];

  // Word storage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= `RST_PRESET;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data <= `RST_PRESET;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      all_words[i] = mem[i];
    end
  end

endmodule : preset_store

// [rtl/rise_detect.sv]
`timescale 1ns/100ps

// Rising edge finder over a bit vector
module rise_detect #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] level_d;

  // Previous value, starts low like the control word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_d <= '0;
    end else begin
      level_d <= level;
    end
  end

  // High only on a 0 to 1 change
  assign rise = level & ~level_d;

endmodule : rise_detect

// [tb/error_counter_preload_test.sv]
`timescale 1ns/100ps
`include "preload_consts.svh"

module error_counter_preload_test;
  logic        clk = 0, rst_b = 0, wr_stb = 0, rd_stb = 0;
  logic  [4:0] addr = 5'h00;
  logic  [7:0] wr_data = 8'h00, rd_data, ber_count, alarm_crc_count;
  logic  [7:0] frame_align_count, ebit_count, crc4_count;
  logic  [5:0] count_inc = 6'h00, load_pulse;
  logic [15:0] bipolar_count;
  int          bad_count = 0, cmp_count = 0;
  logic  [4:0] pa [6] = '{5'h18, 5'h19, 5'h1a, 5'h1c, 5'h1e, 5'h1f};

  error_counter_preload error_counter_preload_inst (.clk, .rst_b, .addr, .wr_data, .wr_stb,
    .rd_stb, .count_inc, .rd_data, .ber_count, .alarm_crc_count, .frame_align_count,
    .bipolar_count, .ebit_count, .crc4_count, .load_pulse);

  // Clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end

  task chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // Read, data checked in the cycle after the strobe
  task rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk("read", {8'h00, exp}, {8'h00, rd_data});
  endtask : rd_chk

  function logic [15:0] cnt(input int n);
    case (n)
      0: return {8'h00, ber_count};
      1: return {8'h00, alarm_crc_count};
      2: return {8'h00, frame_align_count};
      3: return bipolar_count;
      4: return {8'h00, ebit_count};
      default: return {8'h00, crc4_count};
    endcase
  endfunction : cnt

  // Preset chosen for counter n
  function logic [15:0] pv(input int n);
    return (n == 3) ? 16'h445a : {8'h00, 8'(8'h11 * (n + 1))};
  endfunction : pv

  // Control write, then pulse and counter one edge later
  task ld_chk(input logic [7:0] ctl, input logic [5:0] exp_p, input int n,
              input logic [15:0] exp_c);
    wr(`OFF_LOAD_CONTROL, ctl);
    @(posedge clk);
    #1 chk("load_pulse", {10'h000, exp_p}, {10'h000, load_pulse});
    chk("counter", exp_c, cnt(n));
  endtask : ld_chk

  task results;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // Watchdog
  initial begin
    #100000;
    bad_count++;
    results();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(`OFF_LOAD_CONTROL, 8'h00);
    rd_chk(`OFF_MODE_CONTROL, 8'h01);
    rd_chk(5'h1b, 8'h00);
    for (int n = 0; n < 6; n++) begin
      rd_chk(pa[n], 8'h00);
      chk("counter", 16'h0000, cnt(n));
      wr(pa[n], 8'(pv(n) >> ((n == 3) ? 8 : 0)));
      rd_chk(pa[n], 8'(pv(n) >> ((n == 3) ? 8 : 0)));
    end
    wr(`OFF_BPV_PRESET_LO, 8'h5a);
    rd_chk(`OFF_BPV_PRESET_LO, 8'h5a);
    ld_chk(8'hc0, 6'h00, 0, 16'h0000);
    rd_chk(`OFF_LOAD_CONTROL, 8'h00);
    for (int n = 0; n < 6; n++) ld_chk(8'h01 << n, 6'h01 << n, n, pv(n));
    wr(pa[5], 8'hee);
    ld_chk(8'h3f, 6'h1f, 5, 16'h0066);
    wr(`OFF_MODE_CONTROL, 8'h00);
    wr(`OFF_LOAD_CONTROL, 8'h00);
    ld_chk(8'h3f, 6'h00, 5, 16'h0066);
    wr(`OFF_MODE_CONTROL, 8'h01);
    wr(`OFF_LOAD_CONTROL, 8'h00);
    ld_chk(8'h3f, 6'h3f, 5, 16'h00ee);
    rd_chk(`OFF_BPV_COUNT_HI, 8'h44);
    rd_chk(`OFF_BPV_COUNT_LO, 8'h5a);
    rd_chk(`OFF_BER_COUNT, 8'h11);
    rd_chk(`OFF_CRC4_COUNT, 8'hee);
    results();
  end
endmodule : error_counter_preload_test

// [tb/preload_monitor.sv]
`timescale 1ns/100ps
`include "preload_consts.svh"

module preload_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic  [4:0] addr,
  input wire logic  [7:0] wr_data,
  input wire logic        wr_stb,
  input wire logic  [7:0] ber_count,
  input wire logic  [7:0] alarm_crc_count,
  input wire logic  [7:0] frame_align_count,
  input wire logic [15:0] bipolar_count,
  input wire logic  [7:0] ebit_count,
  input wire logic  [7:0] crc4_count,
  input wire logic  [5:0] load_pulse
);
  logic [7:0] shadow [32];
  logic [5:0] exp_pulse;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Mirror of every written register
  always_ff @(posedge clk) begin
    for (int i = 0; i < 32; i++) begin
      if (!rst_b) shadow[i] <= (i == `OFF_MODE_CONTROL) ? 8'h01 : 8'h00;
      else if (wr_stb && addr == 5'(i)) shadow[i] <= wr_data;
    end
  end

  // Loads expected from rising trigger bits in serial mode
  always_ff @(posedge clk) begin
    if (!rst_b || !wr_stb || addr != `OFF_LOAD_CONTROL || !shadow[`OFF_MODE_CONTROL][0])
      exp_pulse <= 6'h00;
    else exp_pulse <= wr_data[5:0] & ~shadow[`OFF_LOAD_CONTROL][5:0];
  end

  // Pulse shows one edge after the control register took the write
  property p_pulse; load_pulse == $past(exp_pulse); endproperty
  a_pulse: assert property (p_pulse) else $error("load pulse wrong");
  property p_once; (load_pulse & $past(load_pulse)) == 6'h00; endproperty
  a_once: assert property (p_once) else $error("load on held trigger");
  property p_ber; load_pulse[0] |-> ber_count == $past(shadow[`OFF_BER_PRESET]); endproperty
  a_ber: assert property (p_ber) else $error("ber load wrong");
  property p_alarm; load_pulse[1] |-> alarm_crc_count == $past(shadow[`OFF_ALARM_PRESET]);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm load wrong");
  property p_frame; load_pulse[2] |-> frame_align_count == $past(shadow[`OFF_FRAME_PRESET]);
  endproperty
  a_frame: assert property (p_frame) else $error("frame load wrong");
  property p_bpv; load_pulse[3] |-> bipolar_count ==
    {$past(shadow[`OFF_BPV_PRESET_HI]), $past(shadow[`OFF_BPV_PRESET_LO])}; endproperty
  a_bpv: assert property (p_bpv) else $error("bipolar load wrong");
  property p_ebit; load_pulse[4] |-> ebit_count == $past(shadow[`OFF_EBIT_PRESET]); endproperty
  a_ebit: assert property (p_ebit) else $error("ebit load wrong");
  property p_crc4; load_pulse[5] |-> crc4_count == $past(shadow[`OFF_CRC4_PRESET]); endproperty
  a_crc4: assert property (p_crc4) else $error("crc4 load wrong");
  // Rising trigger write in serial mode, then a pulse two edges on
  sequence s_rise_wr;
    wr_stb && addr == `OFF_LOAD_CONTROL && shadow[`OFF_MODE_CONTROL][0] &&
      (wr_data[5:0] & ~shadow[`OFF_LOAD_CONTROL][5:0]) != 6'h00;
  endsequence
  sequence s_loaded;
    ##2 load_pulse != 6'h00;
  endsequence
  property p_load_seq; s_rise_wr |-> s_loaded; endproperty
  a_load_seq: assert property (p_load_seq) else $error("no load after trigger");
endmodule : preload_monitor

bind error_counter_preload preload_monitor monitor_inst (.clk, .rst_b, .addr, .wr_data,
  .wr_stb, .ber_count, .alarm_crc_count, .frame_align_count, .bipolar_count, .ebit_count,
  .crc4_count, .load_pulse);
